// *** msv_regs.svh ***
// Function
// [R1] single momentary switch: start in memory A, each press advances to next valid memory
// [R2] press in last valid memory wraps to memory A; one valid memory keeps A
// [R3] selection among at most four memories using one or two switch inputs
// [R4] each select input: momentary or static, pull-up or pull-down by config bit; second input only read as a level, MSV_B_MS2_STATIC unused
// [R5] every memory change fades the audio out; optional tone, one per memory
// [R6] automatic telecoil on: closing the second select switch moves to memory D
// [R7] telecoil switch debounced open: return to memory active before D
// [R8] leave memory D only after switch sampled open for whole debounce period; code skips the period if MSV_B_AUTO_TC is cleared while in D
// [R9] digital volume: up pin closure raises gain, down pin closure lowers it
// [R10] only analog or digital external volume at once, else software volume
// [R11] digital volume accepts momentary or rocker; rocker may also select memory
// [R12] four trimmers map onto up to nineteen parameters of sixteen settings each
// [R13] trimmer and pot positions monitored continuously, changes applied at once
// [R14] momentary inputs synchronised and edge detected: one step per press
// [R15] debounce counter restarts on closed sample, leaves D at programmed count
`ifndef MSV_REGS_SVH
`define MSV_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MSV_ADDR_CTRL      8'h00
`define MSV_ADDR_VALID     8'h04
`define MSV_ADDR_DEBOUNCE  8'h08
`define MSV_ADDR_VOLUME    8'h0c
`define MSV_ADDR_FADE      8'h10
`define MSV_ADDR_TONE      8'h14
`define MSV_ADDR_STATUS    8'h18
`define MSV_MAP_FIRST      6'h10
`define MSV_MAP_LAST       6'h22

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define MSV_CTRL_W         10
`define MSV_CTRL_RST       10'h000
`define MSV_B_MS1_STATIC   0
`define MSV_B_MS2_STATIC   1
`define MSV_B_MS1_PULLUP   2
`define MSV_B_MS2_PULLUP   3
`define MSV_B_AUTO_TC      4
`define MSV_B_VC_ANALOG    5
`define MSV_B_VC_DIGITAL   6
`define MSV_B_ROCKER_MS    7
`define MSV_B_TONE_EN      8
`define MSV_B_TRIM_EN      9
`define MSV_VALID_RST      3'h1
`define MSV_VALID_MAX      3'h4
`define MSV_DEB_RST        16'h0400
`define MSV_FADE_RST       16'h0100
`define MSV_TONE_RST       16'h0400
`define MSV_VOL_RST        6'h20
`define MSV_VOL_MAX        6'h3f
`define MSV_MEM_A          2'h0
`define MSV_MEM_D          2'h3
`define MSV_NTRIM          4
`define MSV_NPARAM         19
`define MSV_PW             4

`endif

// *** msv_pkg.sv ***
package msv_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FADE = 3'b010,
    ST_TONE = 3'b100
  } msv_state_t;

  typedef logic [1:0] msv_mem_t;

endpackage : msv_pkg

// *** msv_sync_edge.sv ***
`timescale 1ns/10ps

// two-flop synchroniser per input plus rising-edge pulse
module msv_sync_edge #(
  parameter int N = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] din,
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise
);

  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] last_r;

  genvar g;
  for (g = 0; g < N; g++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_r[g] <= 1'b0;
        sync_r[g] <= 1'b0;
        last_r[g] <= 1'b0;
      end else begin
        meta_r[g] <= din[g];
        sync_r[g] <= meta_r[g];
        last_r[g] <= sync_r[g];
      end
    end
    // one pulse per closure however long the switch is held
    assign rise[g]  = sync_r[g] & ~last_r[g]; // R14
    assign level[g] = sync_r[g];
  end

endmodule : msv_sync_edge

// *** msv_top.sv ***
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "msv_regs.svh"

module msv_top
  import msv_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        MEMORY_SWITCH_ONE,
  input  wire logic        MEMORY_SWITCH_TWO,
  input  wire logic        GAIN_UP_PIN,
  input  wire logic        GAIN_DOWN_PIN,
  input  wire logic [5:0]  VC_POS,
  input  wire logic [15:0] TRIM_POS,
  output logic [1:0]       PULL_UP_EN,
  output logic [1:0]       ACTIVE_MEM,
  output logic             FADE_ACTIVE,
  output logic             TONE_ACTIVE,
  output logic [5:0]       GAIN,
  output logic [75:0]      PARAM_VALUES,
  output logic             PARAM_UPDATE
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [`MSV_CTRL_W-1:0] ctrl_r;
  logic [2:0]             valid_r;
  logic [15:0]            deb_r;
  logic [15:0]            fade_r;
  logic [15:0]            tone_r;
  logic [5:0]             vol_sw_r;
  logic [2:0]             map_r [`MSV_NPARAM];
  logic [31:0]            rdata_r;
  msv_state_t             state_r;
  msv_mem_t               mem_r;
  msv_mem_t               target_r;
  msv_mem_t               saved_r;
  logic                   in_d_r;
  logic [15:0]            cnt_r;
  logic [15:0]            deb_cnt_r;
  logic [5:0]             gain_r;
  logic [75:0]            par_r;
  logic                   par_upd_r;

  // ----------------------------------------------------------------
  // switch sensing
  // ----------------------------------------------------------------
  wire       pu1 = ctrl_r[`MSV_B_MS1_PULLUP];
  wire       pu2 = ctrl_r[`MSV_B_MS2_PULLUP];
  // with a pull-up the closed switch pulls the pin low
  wire [3:0] sw_closed = {GAIN_DOWN_PIN, GAIN_UP_PIN,
                          MEMORY_SWITCH_TWO ^ pu2, MEMORY_SWITCH_ONE ^ pu1}; // R4
  wire [3:0] sw_lvl;
  wire [3:0] sw_rise;

  msv_sync_edge #(.N(4)) u_sync (
    .clk   (CLOCK),
    .rst   (RST),
    .din   (sw_closed),
    .level (sw_lvl),
    .rise  (sw_rise)
  );

  wire ms1_lvl  = sw_lvl[0];
  wire ms2_lvl  = sw_lvl[1];
  wire ms1_rise = sw_rise[0];
  wire up_rise  = sw_rise[2];
  wire dn_rise  = sw_rise[3];

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  wire [5:0] word    = ADDR[7:2];
  wire       map_hit = (word >= `MSV_MAP_FIRST) && (word <= `MSV_MAP_LAST);
  wire [5:0] map_idx = word - `MSV_MAP_FIRST;
  wire       wr_ctrl = WR && (ADDR == `MSV_ADDR_CTRL);
  // digital wins if software asks for both volume sources
  wire [`MSV_CTRL_W-1:0] ctrl_wr = WDATA[`MSV_CTRL_W-1:0] &
       ~(WDATA[`MSV_B_VC_DIGITAL] ? (`MSV_CTRL_W'(1) << `MSV_B_VC_ANALOG) : '0); // R10

  wire [2:0]  wr_cnt   = WDATA[2:0];
  // the count is stored clamped so software reads back the count in use
  wire [2:0]  valid_wr = (wr_cnt == 3'h0) ? 3'h1 :
                         (wr_cnt > `MSV_VALID_MAX) ? `MSV_VALID_MAX : wr_cnt; // R3

  wire [31:0] status = {24'h000000, in_d_r, state_r, target_r, mem_r};
  wire [2:0]  map_rd = map_hit ? map_r[map_idx[4:0]] : 3'h0;
  wire [31:0] rd_nxt =
    (ADDR == `MSV_ADDR_CTRL)     ? {22'h000000, ctrl_r}  :
    (ADDR == `MSV_ADDR_VALID)    ? {29'h00000000, valid_r} :
    (ADDR == `MSV_ADDR_DEBOUNCE) ? {16'h0000, deb_r}      :
    (ADDR == `MSV_ADDR_VOLUME)   ? {26'h0000000, gain_r}  :
    (ADDR == `MSV_ADDR_FADE)     ? {16'h0000, fade_r}     :
    (ADDR == `MSV_ADDR_TONE)     ? {16'h0000, tone_r}     :
    (ADDR == `MSV_ADDR_STATUS)   ? status                 :
    map_hit                      ? {29'h00000000, map_rd} : 32'h00000000;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_r   <= `MSV_CTRL_RST;
      valid_r  <= `MSV_VALID_RST;
      deb_r    <= `MSV_DEB_RST;
      fade_r   <= `MSV_FADE_RST;
      tone_r   <= `MSV_TONE_RST;
      vol_sw_r <= `MSV_VOL_RST;
      rdata_r  <= 32'h00000000;
    end else begin
      if (wr_ctrl) ctrl_r <= ctrl_wr;
      if (WR && ADDR == `MSV_ADDR_VALID) valid_r <= valid_wr; // R3
      if (WR && ADDR == `MSV_ADDR_DEBOUNCE) deb_r <= WDATA[15:0];
      if (WR && ADDR == `MSV_ADDR_VOLUME) vol_sw_r <= WDATA[5:0];
      if (WR && ADDR == `MSV_ADDR_FADE) fade_r <= WDATA[15:0];
      if (WR && ADDR == `MSV_ADDR_TONE) tone_r <= WDATA[15:0];
      rdata_r <= RD ? rd_nxt : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // memory selection
  // ----------------------------------------------------------------
  wire tc_en     = ctrl_r[`MSV_B_AUTO_TC];
  wire ms1_stat  = ctrl_r[`MSV_B_MS1_STATIC];
  wire vc_dig    = ctrl_r[`MSV_B_VC_DIGITAL];
  wire vc_ana    = ctrl_r[`MSV_B_VC_ANALOG] & ~vc_dig; // R10
  wire rocker_ms = ctrl_r[`MSV_B_ROCKER_MS] & vc_dig;
  wire idle      = (state_r == ST_IDLE);

  // at most four memories; telecoil reserves D so cycling stops at C
  wire [2:0] vcnt  = (valid_r == 3'h0) ? 3'h1 :
                     (valid_r > `MSV_VALID_MAX) ? `MSV_VALID_MAX : valid_r; // R3
  wire [2:0] limit = (tc_en && vcnt == `MSV_VALID_MAX) ? 3'h3 : vcnt;
  wire [2:0] inc   = {1'b0, mem_r} + 3'h1;
  wire [2:0] lim_m = limit - 3'h1;
  wire [1:0] mem_next = (inc >= limit) ? `MSV_MEM_A : inc[1:0]; // R1 R2
  wire [1:0] mem_prev = (mem_r == `MSV_MEM_A) ? lim_m[1:0] : mem_r - 2'h1;
  wire [1:0] stat_raw = {ms2_lvl & ~tc_en, ms1_lvl};
  wire [2:0] stat_w   = {1'b0, stat_raw};
  wire [1:0] stat_sel = (stat_w >= vcnt) ? `MSV_MEM_A : stat_raw;

  wire tc_close = idle & tc_en & ms2_lvl & ~in_d_r; // R6
  wire deb_done = idle & in_d_r & ~ms2_lvl & (~tc_en | (deb_cnt_r >= deb_r)); // R8 R15
  wire stat_req = idle & ms1_stat & ~in_d_r & (stat_sel != mem_r);
  wire mom_req  = idle & ~ms1_stat & ms1_rise & ~in_d_r; // R1 R14
  wire rock_req = idle & rocker_ms & ~in_d_r & (up_rise | dn_rise); // R11
  wire [1:0] req_mem = tc_close ? `MSV_MEM_D :
                       deb_done ? saved_r    :
                       stat_req ? stat_sel   :
                       mom_req  ? mem_next   :
                       up_rise  ? mem_next   : mem_prev;
  wire go = tc_close | deb_done |
            ((stat_req | mom_req | rock_req) & (req_mem != mem_r));
  wire cnt_done = (state_r == ST_FADE) ? (cnt_r >= fade_r) : (cnt_r >= tone_r);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r  <= ST_IDLE;
      mem_r    <= `MSV_MEM_A;
      target_r <= `MSV_MEM_A;
      saved_r  <= `MSV_MEM_A;
      in_d_r   <= 1'b0;
      cnt_r    <= 16'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= 16'h0000;
          if (go) begin
            state_r  <= ST_FADE; // R5
            target_r <= req_mem;
          end
          if (tc_close) begin
            in_d_r  <= 1'b1;
            saved_r <= mem_r; // R7
          end
          if (deb_done) in_d_r <= 1'b0; // R7
        end
        ST_FADE: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_done) begin
            // switch parameters only while the audio is faded out
            mem_r   <= target_r;
            cnt_r   <= 16'h0000;
            state_r <= ctrl_r[`MSV_B_TONE_EN] ? ST_TONE : ST_IDLE; // R5
          end
        end
        ST_TONE: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_done) state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // closed sample restarts the open-check interval
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) deb_cnt_r <= 16'h0000;
    else if (!in_d_r || ms2_lvl) deb_cnt_r <= 16'h0000; // R15
    else if (deb_cnt_r < deb_r) deb_cnt_r <= deb_cnt_r + 16'h0001; // R8
  end

  // ----------------------------------------------------------------
  // volume
  // ----------------------------------------------------------------
  wire up_ok = up_rise & (gain_r != `MSV_VOL_MAX);
  wire dn_ok = dn_rise & (gain_r != 6'h00);
  wire [5:0] dig_gain = up_ok ? gain_r + 6'h01 :
                        dn_ok ? gain_r - 6'h01 : gain_r; // R9
  wire [5:0] gain_nxt = vc_ana ? VC_POS :
                        (vc_dig & ~rocker_ms) ? dig_gain : vol_sw_r; // R10 R13

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) gain_r <= `MSV_VOL_RST;
    else gain_r <= gain_nxt;
  end

  // ----------------------------------------------------------------
  // trimmer map
  // ----------------------------------------------------------------
  wire        trim_en = ctrl_r[`MSV_B_TRIM_EN];
  wire [75:0] par_nxt;

  genvar g;
  for (g = 0; g < `MSV_NPARAM; g++) begin : g_par
    wire [3:0] tpos = TRIM_POS[map_r[g][1:0]*`MSV_PW +: `MSV_PW];
    // several parameters may follow one trimmer
    assign par_nxt[g*`MSV_PW +: `MSV_PW] = (trim_en && map_r[g][2]) ? tpos :
                                            par_r[g*`MSV_PW +: `MSV_PW]; // R12 R13
    always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) map_r[g] <= 3'h0;
      else if (WR && map_hit && map_idx == g) map_r[g] <= WDATA[2:0];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      par_r     <= 76'h0;
      par_upd_r <= 1'b0;
    end else begin
      par_r     <= par_nxt;
      par_upd_r <= (par_nxt != par_r); // R13
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RDATA        = rdata_r;
  assign PULL_UP_EN   = {pu2, pu1}; // R4
  assign ACTIVE_MEM   = mem_r;
  assign FADE_ACTIVE  = state_r[1];
  assign TONE_ACTIVE  = state_r[2];
  assign GAIN         = gain_r;
  assign PARAM_VALUES = par_r;
  assign PARAM_UPDATE = par_upd_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  AST_ADVANCE: assert property (mom_req && !tc_close && mem_next != mem_r |=> // R1
    state_r == ST_FADE && target_r == $past(mem_next)) else $error("no advance on press");
  AST_WRAP: assert property (mom_req && !tc_close && inc >= limit && mem_r != `MSV_MEM_A |=> // R2
    target_r == `MSV_MEM_A) else $error("no wrap to memory A");
  AST_FADE_FIRST: assert property ($changed(mem_r) |-> // R5
    $past(state_r) == ST_FADE) else $error("memory changed without fade");
  AST_FADE_LEN: assert property (state_r == ST_FADE && cnt_r < fade_r |=> // R5
    state_r == ST_FADE) else $error("fade ended early");
  AST_TC_D: assert property (tc_close |=> target_r == `MSV_MEM_D && in_d_r // R6
    ##[1:1000] (state_r != ST_FADE && mem_r == `MSV_MEM_D)) else $error("no move to D");
  AST_TC_RET: assert property (deb_done && tc_en |=> !in_d_r && // R7
    target_r == $past(saved_r)) else $error("no return from D");
  AST_DEB_OPEN: assert property (in_d_r && tc_en && deb_cnt_r < deb_r |=> // R8
    in_d_r && target_r == `MSV_MEM_D) else $error("left D before period");
  AST_DEB_RST: assert property (in_d_r && ms2_lvl |=> deb_cnt_r == 16'h0000) // R15
    else $error("debounce not restarted");
  AST_GAIN_UP: assert property (vc_dig && !rocker_ms && up_ok && !vc_ana |=> // R9
    gain_r == $past(gain_r) + 6'h01) else $error("gain not raised");
  AST_VC_ONE: assert property (!(ctrl_r[`MSV_B_VC_ANALOG] && ctrl_r[`MSV_B_VC_DIGITAL])) // R10
    else $error("both volume sources on");
  AST_ONE_STEP: assert property (ms1_rise |=> !ms1_rise) // R14
    else $error("double step on one press");
  AST_TRIM: assert property (trim_en && map_r[0][2] && $stable(TRIM_POS) // R12
    && $stable(map_r[0]) |=> par_r[3:0] == $past(TRIM_POS[map_r[0][1:0]*4 +: 4]))
    else $error("trimmer not applied");

  COV_ADVANCE: cover property (mom_req ##1 state_r == ST_FADE);
  COV_TC_CYCLE: cover property (tc_close ##[1:1000] deb_done);
  COV_TONE: cover property (state_r == ST_FADE ##1 state_r == ST_TONE);
  COV_ROCKER: cover property (rock_req && dn_rise);

endmodule : msv_top

// *** msv_switch_model.sv ***
`timescale 1ns/10ps

// ------------------------------------------------------------
// user switches as wired to the pins
// ------------------------------------------------------------
// a switch wired against a pull-up shorts the pin low when closed;
// an open switch leaves the pin at the level of its pull resistor
module msv_switch_model (
  input  wire logic [1:0] pull_up_en,
  input  wire logic       close_one,
  input  wire logic       close_two,
  input  wire logic       close_up,
  input  wire logic       close_down,
  output logic            pin_one,
  output logic            pin_two,
  output logic            pin_up,
  output logic            pin_down
);
  assign pin_one  = pull_up_en[0] ? ~close_one : close_one;
  assign pin_two  = pull_up_en[1] ? ~close_two : close_two;
  assign pin_up   = close_up;
  assign pin_down = close_down;
endmodule : msv_switch_model

// *** tb.sv ***
`timescale 1ns/10ps
`include "msv_regs.svh"

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module tb;
  import msv_pkg::*;
  logic        CLOCK = 0, RST = 1, WR = 0, RD = 0;
  logic [7:0]  ADDR = 0;
  logic [31:0] WDATA = 0, RDATA, rv;
  logic [5:0]  VC_POS = 0, GAIN;
  logic [15:0] TRIM_POS = 0;
  logic [1:0]  PULL_UP_EN, ACTIVE_MEM;
  logic        FADE_ACTIVE, TONE_ACTIVE, PARAM_UPDATE;
  logic [75:0] PARAM_VALUES;
  logic        c1 = 0, c2 = 0, cu = 0, cd = 0, p1, p2, pu, pd;
  logic        saw_fade = 0, saw_tone = 0, saw_upd = 0;
  int          miscompares = 0, num_checks = 0, cyc = 0;

  always #10 CLOCK = ~CLOCK;

  msv_switch_model user (.pull_up_en(PULL_UP_EN), .close_one(c1), .close_two(c2),
    .close_up(cu), .close_down(cd), .pin_one(p1), .pin_two(p2), .pin_up(pu), .pin_down(pd));

  msv_top DUT (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .MEMORY_SWITCH_ONE(p1), .MEMORY_SWITCH_TWO(p2), .GAIN_UP_PIN(pu),
    .GAIN_DOWN_PIN(pd), .VC_POS(VC_POS), .TRIM_POS(TRIM_POS), .PULL_UP_EN(PULL_UP_EN),
    .ACTIVE_MEM(ACTIVE_MEM), .FADE_ACTIVE(FADE_ACTIVE), .TONE_ACTIVE(TONE_ACTIVE),
    .GAIN(GAIN), .PARAM_VALUES(PARAM_VALUES), .PARAM_UPDATE(PARAM_UPDATE));

  // ------------------------------------------------------------
  // monitors and timeout
  // ------------------------------------------------------------
  always @(posedge CLOCK) begin
    if (FADE_ACTIVE === 1'b1) saw_fade <= 1'b1;
    if (TONE_ACTIVE === 1'b1) saw_tone <= 1'b1;
    if (PARAM_UPDATE === 1'b1) saw_upd <= 1'b1;
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // bus and switch helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge CLOCK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask : rd

  task automatic do_reset();
    @(posedge CLOCK);
    RST <= 1'b1; c1 <= 0; c2 <= 0; cu <= 0; cd <= 0;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
  endtask : do_reset

  // bounded wait until the fade/tone sequence is over
  task automatic wait_idle(input int pre);
    int i;
    repeat (pre) @(posedge CLOCK);
    for (i = 0; i < 500 && (FADE_ACTIVE !== 1'b0 || TONE_ACTIVE !== 1'b0); i++)
      @(posedge CLOCK);
  endtask : wait_idle

  // held far longer than the fade so a repeat step would show
  task automatic press_one();
    @(posedge CLOCK);
    saw_fade <= 0; saw_tone <= 0; c1 <= 1'b1;
    repeat (20) @(posedge CLOCK);
    c1 <= 1'b0;
    wait_idle(3);
  endtask : press_one

  task automatic vol_step(input logic up);
    @(posedge CLOCK);
    if (up) cu <= 1'b1; else cd <= 1'b1;
    repeat (6) @(posedge CLOCK);
    cu <= 1'b0; cd <= 1'b0;
    repeat (4) @(posedge CLOCK);
  endtask : vol_step

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    do_reset();
    `CHK("mem", `MSV_MEM_A, ACTIVE_MEM)
    rd(`MSV_ADDR_CTRL);     `CHK("ctrl", 32'h0, rv)
    rd(`MSV_ADDR_DEBOUNCE); `CHK("deb", 32'h400, rv)
    rd(`MSV_ADDR_VOLUME);   `CHK("vol", 32'h20, rv)
    rd(8'h3c);              `CHK("unmapped", 32'h0, rv)
    wr(`MSV_ADDR_VALID, 32'h7);
    rd(`MSV_ADDR_VALID);    `CHK("valid max", 32'h4, rv)
    $display("test reset done");
  endtask : t_reset

  task automatic t_cycle();
    int k;
    do_reset();
    wr(`MSV_ADDR_CTRL, 32'h4);
    wr(`MSV_ADDR_VALID, 32'h4);
    wr(`MSV_ADDR_FADE, 32'h4);
    `CHK("pull", 2'h1, PULL_UP_EN)
    for (k = 1; k <= 4; k++) begin
      press_one();
      `CHK("mem step", 2'(k % 4), ACTIVE_MEM)
      `CHK("fade", 1'b1, saw_fade)
    end
    wr(`MSV_ADDR_VALID, 32'h1);
    press_one();
    `CHK("one valid", `MSV_MEM_A, ACTIVE_MEM)
    wr(`MSV_ADDR_CTRL, 32'h100);
    wr(`MSV_ADDR_VALID, 32'h2);
    wr(`MSV_ADDR_TONE, 32'h4);
    press_one();
    `CHK("tone", 1'b1, saw_tone)
    `CHK("mem b", 2'h1, ACTIVE_MEM)
    wr(`MSV_ADDR_CTRL, 32'h1);
    wait_idle(4);
    `CHK("static open", `MSV_MEM_A, ACTIVE_MEM)
    c1 <= 1'b1;
    wait_idle(4);
    `CHK("static closed", 2'h1, ACTIVE_MEM)
    $display("test memory cycling done");
  endtask : t_cycle

  task automatic t_tcoil();
    do_reset();
    wr(`MSV_ADDR_CTRL, 32'h10);
    wr(`MSV_ADDR_VALID, 32'h3);
    wr(`MSV_ADDR_FADE, 32'h4);
    wr(`MSV_ADDR_DEBOUNCE, 32'h8);
    press_one();
    @(posedge CLOCK) c2 <= 1'b1;
    wait_idle(4);
    `CHK("to d", `MSV_MEM_D, ACTIVE_MEM)
    @(posedge CLOCK) c2 <= 1'b0;
    repeat (6) @(posedge CLOCK);
    c2 <= 1'b1;
    repeat (4) @(posedge CLOCK);
    c2 <= 1'b0;
    repeat (7) @(posedge CLOCK);
    #1 `CHK("held d", `MSV_MEM_D, ACTIVE_MEM)
    `CHK("no fade", 1'b0, FADE_ACTIVE)
    wait_idle(8);
    `CHK("back", 2'h1, ACTIVE_MEM)
    $display("test telecoil done");
  endtask : t_tcoil

  task automatic t_volume();
    int k;
    do_reset();
    wr(`MSV_ADDR_CTRL, 32'h40);
    for (k = 0; k < 70; k++) vol_step(1'b0);
    `CHK("gain floor", 6'h00, GAIN)
    vol_step(1'b1);
    `CHK("gain up", 6'h01, GAIN)
    VC_POS <= 6'h2a;
    wr(`MSV_ADDR_CTRL, 32'h60);
    rd(`MSV_ADDR_CTRL); `CHK("exclusive", 32'h40, rv)
    wr(`MSV_ADDR_CTRL, 32'h20);
    repeat (4) @(posedge CLOCK);
    `CHK("analog", 6'h2a, GAIN)
    wr(`MSV_ADDR_CTRL, 32'hc0);
    wr(`MSV_ADDR_VALID, 32'h4);
    wr(`MSV_ADDR_FADE, 32'h4);
    vol_step(1'b1);
    wait_idle(2);
    `CHK("rocker", 2'h1, ACTIVE_MEM)
    vol_step(1'b0);
    wait_idle(2);
    `CHK("rocker down", `MSV_MEM_A, ACTIVE_MEM)
    `CHK("rocker gain", 6'h20, GAIN)
    $display("test volume done");
  endtask : t_volume

  task automatic t_trim();
    do_reset();
    wr(`MSV_ADDR_CTRL, 32'h200);
    wr(8'h40, 32'h6);
    wr(8'h88, 32'h4);
    rd(8'h40); `CHK("map", 32'h6, rv)
    TRIM_POS <= 16'h0905;
    repeat (6) @(posedge CLOCK);
    `CHK("p0", 4'h9, PARAM_VALUES[3:0])
    `CHK("p18", 4'h5, PARAM_VALUES[75:72])
    `CHK("p1", 4'h0, PARAM_VALUES[7:4])
    saw_upd <= 1'b0;
    TRIM_POS <= 16'h0a05;
    repeat (8) @(posedge CLOCK);
    `CHK("upd", 1'b1, saw_upd)
    `CHK("p0 new", 4'ha, PARAM_VALUES[3:0])
    $display("test trimmers done");
  endtask : t_trim

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    t_reset();
    t_cycle();
    t_tcoil();
    t_volume();
    t_trim();
    end_of_test();
  end
endmodule : tb
